// file: pixel_memory_clock_synth_regs.sv
`include "clk_synth_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module pixel_memory_clock_synth_regs #(
  parameter int NUM_VCLK = 3
) (
  input wire logic sys_clk, // 250 mhz clock
  input wire logic srst, // sync reset, active high
  input wire logic [7:0] reg_index, // index register contents
  input wire logic reg_wr, // data port write strobe
  input wire logic reg_rd, // data port read strobe
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid cycle after strobe
  input wire logic vclk_src_strap, // 1 internal vco source, async pin
  output logic vclk_vco_en, // video vco enable
  output logic [29:0] vco_m, // working M per video clock, 10 bits each
  output logic [29:0] vco_n, // working N per video clock
  output logic [8:0] vco_post_div_log2, // shift count per video clock
  output logic [14:0] vco_loop_mul, // 4 or 16 per video clock
  output logic [8:0] vco_ref_pre_div, // 1 or 5 per video clock
  output logic [8:0] vco_ref_sel_div, // 4 or 1 per video clock
  output logic vclk2_use_memclk, // video clock 2 driven by memory clock
  output logic [6:0] mem_m, // memory vco M
  output logic [6:0] mem_n, // memory vco N
  output logic [2:0] mem_post_div_log2, // memory post divisor shift
  output logic [2:0] mem_ref_sel_div, // memory reference divide
  output logic mem_use_prog, // 0 default 25.175 mhz, 1 programmed
  output logic [3:0] vclk_commit // pulse: video clock working regs loaded
);

  // =====================================================
  // decode helpers
  function automatic logic [2:0] ref_sel_div(input logic b);
    ref_sel_div = b ? `REFSEL_DIV1 : `REFSEL_DIV4;
  endfunction

  function automatic logic [4:0] loop_mul(input logic b);
    loop_mul = b ? `LOOP_MUL_HIGH : `LOOP_MUL_LOW;
  endfunction

  function automatic logic [2:0] ref_pre_div(input logic b);
    ref_pre_div = b ? `REFDIV5_VAL : 3'h1;
  endfunction

  // =====================================================
  // strap synchroniser
  logic strap_s1_reg;
  logic strap_s2_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
    end else begin
      strap_s1_reg <= vclk_src_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vclk_vco_en <= 1'b0;
    end else begin
      vclk_vco_en <= strap_s2_reg;
    end
  end

  // =====================================================
  // video clock staging and working registers
  clk_synth_pkg::reg8_type stg_m_reg [NUM_VCLK];
  clk_synth_pkg::reg8_type stg_n_reg [NUM_VCLK];
  clk_synth_pkg::reg8_type stg_hi_reg [NUM_VCLK];
  clk_synth_pkg::reg8_type dsel_reg [NUM_VCLK];
  logic [NUM_VCLK-1:0] commit_next;

  genvar g;
  generate
    for (g = 0; g < NUM_VCLK; g++) begin : g_vclk
      localparam logic [7:0] BASE = 8'(`IDX_VCLK0_M + 4 * g);
      localparam logic [7:0] DMASK = (g == 2) ? `VDSEL2_MASK : `VDSEL_MASK;
      logic wr_m;
      logic wr_n;
      logic wr_hi;
      logic wr_d;
      clk_synth_pkg::post_code_type post;

      assign wr_m = reg_wr && (reg_index == BASE);
      assign wr_n = reg_wr && (reg_index == 8'(BASE + 8'h1));
      assign wr_hi = reg_wr && (reg_index == 8'(BASE + 8'h2));
      assign wr_d = reg_wr && (reg_index == 8'(BASE + 8'h3));
      assign commit_next[g] = wr_d;
      assign post = dsel_reg[g][`DSEL_POST_LSB +: 3];

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          stg_m_reg[g] <= `RST_REG;
          stg_n_reg[g] <= `RST_REG;
          stg_hi_reg[g] <= `RST_REG;
          dsel_reg[g] <= `RST_REG;
        end else begin
          if (wr_m) begin
            stg_m_reg[g] <= reg_wdata;
          end
          if (wr_n) begin
            stg_n_reg[g] <= reg_wdata;
          end
          if (wr_hi) begin
            stg_hi_reg[g] <= reg_wdata & `HI_MASK;
          end
          if (wr_d) begin
            dsel_reg[g] <= reg_wdata & DMASK;
          end
        end
      end

      // working set loads once, after the select write, so staged
      // values never reach the vco half-programmed
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          vco_m[g*10 +: 10] <= 10'h000;
          vco_n[g*10 +: 10] <= 10'h000;
        end else if (wr_d) begin
          vco_m[g*10 +: 10] <= {stg_hi_reg[g][`HI_M_LSB +: 2],
                                stg_m_reg[g]};
          vco_n[g*10 +: 10] <= {stg_hi_reg[g][`HI_N_LSB +: 2],
                                stg_n_reg[g]};
        end
      end

      // divisor fields follow the select register, one edge after it is written
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          vco_post_div_log2[g*3 +: 3] <= 3'h0;
          vco_loop_mul[g*5 +: 5] <= `LOOP_MUL_LOW;
          vco_ref_pre_div[g*3 +: 3] <= 3'h1;
          vco_ref_sel_div[g*3 +: 3] <= `REFSEL_DIV4;
        end else begin
          // reserved codes hold at divide by 32
          vco_post_div_log2[g*3 +: 3] <= (post > 3'h5) ? 3'h5 : post;
          vco_loop_mul[g*5 +: 5] <=
            loop_mul(dsel_reg[g][`DSEL_LOOP_BIT]);
          vco_ref_pre_div[g*3 +: 3] <=
            ref_pre_div(dsel_reg[g][`DSEL_REFDIV5_BIT]);
          vco_ref_sel_div[g*3 +: 3] <=
            ref_sel_div(dsel_reg[g][`DSEL_REFSEL_BIT]);
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vclk_commit <= 4'h0;
      vclk2_use_memclk <= 1'b0;
    end else begin
      vclk_commit <= 4'({1'b0, commit_next});
      vclk2_use_memclk <= dsel_reg[2][`DSEL_SRC_BIT];
    end
  end

  // =====================================================
  // memory clock registers, applied directly (no staging)
  clk_synth_pkg::reg8_type mem_m_reg;
  clk_synth_pkg::reg8_type mem_n_reg;
  clk_synth_pkg::reg8_type mem_dsel_reg;
  clk_synth_pkg::post_code_type mpost;

  assign mpost = mem_dsel_reg[`DSEL_POST_LSB +: 3];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_m_reg <= `RST_REG;
      mem_n_reg <= `RST_REG;
      mem_dsel_reg <= `RST_REG;
    end else if (reg_wr) begin
      // host is expected to drop to the default clock first; not enforced
      if (reg_index == `IDX_MEM_M) begin
        mem_m_reg <= reg_wdata & `MEM_MN_MASK;
      end
      if (reg_index == `IDX_MEM_N) begin
        mem_n_reg <= reg_wdata & `MEM_MN_MASK;
      end
      if (reg_index == `IDX_MEM_DSEL) begin
        mem_dsel_reg <= reg_wdata & `MDSEL_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_m <= 7'h00;
      mem_n <= 7'h00;
      mem_post_div_log2 <= 3'h0;
      mem_ref_sel_div <= `REFSEL_DIV4;
      mem_use_prog <= 1'b0;
    end else begin
      mem_m <= mem_m_reg[6:0];
      mem_n <= mem_n_reg[6:0];
      mem_post_div_log2 <= (mpost > 3'h5) ? 3'h5 : mpost;
      mem_ref_sel_div <= ref_sel_div(mem_dsel_reg[`DSEL_REFSEL_BIT]);
      mem_use_prog <= mem_dsel_reg[`DSEL_SRC_BIT];
    end
  end

  // =====================================================
  // read back; unlisted indices return zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_index)
        `IDX_VCLK0_M: reg_rdata <= stg_m_reg[0];
        `IDX_VCLK0_N: reg_rdata <= stg_n_reg[0];
        `IDX_VCLK0_MN_HI: reg_rdata <= stg_hi_reg[0];
        `IDX_VCLK0_DSEL: reg_rdata <= dsel_reg[0];
        `IDX_VCLK1_M: reg_rdata <= stg_m_reg[1];
        `IDX_VCLK1_N: reg_rdata <= stg_n_reg[1];
        `IDX_VCLK1_MN_HI: reg_rdata <= stg_hi_reg[1];
        `IDX_VCLK1_DSEL: reg_rdata <= dsel_reg[1];
        `IDX_VCLK2_M: reg_rdata <= stg_m_reg[2];
        `IDX_VCLK2_N: reg_rdata <= stg_n_reg[2];
        `IDX_VCLK2_MN_HI: reg_rdata <= stg_hi_reg[2];
        `IDX_VCLK2_DSEL: reg_rdata <= dsel_reg[2];
        `IDX_MEM_M: reg_rdata <= mem_m_reg;
        `IDX_MEM_N: reg_rdata <= mem_n_reg;
        `IDX_MEM_DSEL: reg_rdata <= mem_dsel_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // =====================================================
  // checks
  // staged M write followed by a cycle with no select write
  sequence stage_written_s;
    reg_wr && reg_index == `IDX_VCLK1_M
      ##1 !(reg_wr && reg_index == `IDX_VCLK1_DSEL);
  endsequence

  sequence commit_write_s;
    reg_wr && reg_index == `IDX_VCLK1_DSEL;
  endsequence

  property no_early_load_p;
    @(posedge sys_clk) disable iff (srst)
    stage_written_s |=> $stable(vco_m[19:10]);
  endproperty
  vclk_hold_a: assert property (no_early_load_p)
    else $error("video M changed without select write");

  property commit_load_p;
    @(posedge sys_clk) disable iff (srst)
    commit_write_s |=> vco_m[19:10] == {$past(stg_hi_reg[1][1:0]),
                                        $past(stg_m_reg[1])};
  endproperty
  vclk_commit_a: assert property (commit_load_p)
    else $error("video M not loaded from staged values");

  n_join_a: assert property (@(posedge sys_clk) disable iff (srst)
    commit_write_s |=> vco_n[19:18] == $past(stg_hi_reg[1][5:4]))
    else $error("video N upper bits misplaced");

  // divisor fields lag the select register by one edge
  loop_mul_a: assert property (@(posedge sys_clk) disable iff (srst)
    vco_loop_mul[4:0] == ($past(dsel_reg[0][2]) ? 5'd16 : 5'd4))
    else $error("loop multiplier wrong");

  ref_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    $stable(mem_dsel_reg) |=>
      mem_ref_sel_div == ($past(mem_dsel_reg[0]) ? 3'd1 : 3'd4))
    else $error("memory reference divide wrong");

  mem_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    reg_wr && reg_index == `IDX_MEM_DSEL |=>
      ##1 mem_use_prog == $past(reg_wdata[7], 2))
    else $error("memory clock select not followed");

  mem_resv_a: assert property (@(posedge sys_clk) disable iff (srst)
    mem_m_reg[7] == 1'b0 && mem_dsel_reg[3:1] == 3'h0)
    else $error("memory reserved bit stored");

  strap_en_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(strap_s2_reg) |=> vclk_vco_en)
    else $error("vco enable did not follow strap");

  src2_a: assert property (@(posedge sys_clk) disable iff (srst)
    vclk2_use_memclk |-> $past(dsel_reg[2][7]))
    else $error("video clock 2 source wrong");

  post_a: assert property (@(posedge sys_clk) disable iff (srst)
    vco_post_div_log2[2:0] <= 3'h5)
    else $error("post divisor code out of range");

  ref_pre_a: assert property (@(posedge sys_clk) disable iff (srst)
    vco_ref_pre_div[2:0] == ($past(dsel_reg[0][1]) ? 3'd5 : 3'd1))
    else $error("reference pre-divide wrong");

  vref_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    vco_ref_sel_div[2:0] == ($past(dsel_reg[0][0]) ? 3'd1 : 3'd4))
    else $error("video reference divide wrong");

  // the pulse marks the single edge at which the working set loads
  commit_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
    vclk_commit[1] ==
      $past(reg_wr && reg_index == `IDX_VCLK1_DSEL))
    else $error("commit pulse does not match select write");

  mem_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
    mem_m == $past(mem_m_reg[6:0]) &&
      mem_n == $past(mem_n_reg[6:0]))
    else $error("memory divider not applied");

  unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (srst)
    reg_rd && reg_index == 8'hcf |=> reg_rdata == 8'h00)
    else $error("unmapped index read nonzero");

  vco_en_a: assert property (@(posedge sys_clk) disable iff (srst)
    vclk_vco_en == $past(strap_s2_reg))
    else $error("vco enable differs from synchronised strap");

  sequence src2_write_s;
    reg_wr && reg_index == `IDX_VCLK2_DSEL;
  endsequence

  src2_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
    src2_write_s |=> ##1
      vclk2_use_memclk == $past(reg_wdata[7], 2))
    else $error("video clock 2 source not followed");

endmodule

`default_nettype wire

// file: clk_synth_defines.svh
`ifndef CLK_SYNTH_DEFINES_SVH
`define CLK_SYNTH_DEFINES_SVH

// =====================================================
// register indices (data port with index port selecting)
`define IDX_VCLK0_M 8'hc0
`define IDX_VCLK0_N 8'hc1
`define IDX_VCLK0_MN_HI 8'hc2
`define IDX_VCLK0_DSEL 8'hc3
`define IDX_VCLK1_M 8'hc4
`define IDX_VCLK1_N 8'hc5
`define IDX_VCLK1_MN_HI 8'hc6
`define IDX_VCLK1_DSEL 8'hc7
`define IDX_VCLK2_M 8'hc8
`define IDX_VCLK2_N 8'hc9
`define IDX_VCLK2_MN_HI 8'hca
`define IDX_VCLK2_DSEL 8'hcb
`define IDX_MEM_M 8'hcc
`define IDX_MEM_N 8'hcd
`define IDX_MEM_DSEL 8'hce
// =====================================================
// field positions and writable masks
`define HI_M_LSB 0
`define HI_N_LSB 4
`define HI_MASK 8'h33
`define VDSEL_MASK 8'h77
`define VDSEL2_MASK 8'hf7
`define MEM_MN_MASK 8'h7f
`define MDSEL_MASK 8'hf1
`define DSEL_POST_LSB 4
`define DSEL_LOOP_BIT 2
`define DSEL_REFDIV5_BIT 1
`define DSEL_REFSEL_BIT 0
`define DSEL_SRC_BIT 7
// =====================================================
// reset values
`define RST_REG 8'h00
// ratio constants
`define LOOP_MUL_LOW 5'd4
`define LOOP_MUL_HIGH 5'd16
`define REFDIV5_VAL 3'd5
`define REFSEL_DIV4 3'd4
`define REFSEL_DIV1 3'd1
`define MEM_DEFAULT_KHZ 32'd25175

`endif

// file: clk_synth_pkg.sv
package clk_synth_pkg;
  typedef logic [7:0] reg8_type;
  typedef logic [9:0] div10_type;
  typedef logic [2:0] post_code_type;
endpackage

// file: pixel_memory_clock_synth_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module pixel_memory_clock_synth_regs_tb_top;
  logic sys_clk, srst, reg_wr, reg_rd, vclk_src_strap, vclk_vco_en;
  logic [7:0] reg_index, reg_wdata, reg_rdata;
  logic [29:0] vco_m, vco_n;
  logic [8:0] vco_post_div_log2, vco_ref_pre_div, vco_ref_sel_div;
  logic [14:0] vco_loop_mul;
  logic vclk2_use_memclk, mem_use_prog;
  logic [6:0] mem_m, mem_n;
  logic [2:0] mem_post_div_log2, mem_ref_sel_div;
  logic [3:0] vclk_commit;
  logic [9:0] em [3];
  logic [9:0] en [3];
  int n_mismatch, n_checks, cycles;

  pixel_memory_clock_synth_regs #(.NUM_VCLK(3)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .reg_index(reg_index),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .vclk_src_strap(vclk_src_strap),
    .vclk_vco_en(vclk_vco_en), .vco_m(vco_m), .vco_n(vco_n),
    .vco_post_div_log2(vco_post_div_log2), .vco_loop_mul(vco_loop_mul),
    .vco_ref_pre_div(vco_ref_pre_div), .vco_ref_sel_div(vco_ref_sel_div),
    .vclk2_use_memclk(vclk2_use_memclk), .mem_m(mem_m), .mem_n(mem_n),
    .mem_post_div_log2(mem_post_div_log2),
    .mem_ref_sel_div(mem_ref_sel_div), .mem_use_prog(mem_use_prog),
    .vclk_commit(vclk_commit));

  // ==========================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // whole run is well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge sys_clk);
    reg_index <= idx;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // rdata holds after the answer, so one spare edge is safe
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_index <= idx;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(32'(reg_rdata), 32'(exp));
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic check_reset_values();
    chk(32'(vco_m), 32'h0);
    chk(32'(vco_loop_mul), 32'h1084);
    chk(32'(vco_ref_pre_div), 32'h049);
    chk(32'(vco_ref_sel_div), 32'h124);
    chk(32'(mem_ref_sel_div), 32'h4);
    chk(32'(mem_use_prog), 32'h0);
  endtask

  // reserved bits are written as ones on purpose, except select bit 7, which carries bit 0 of the code
  task automatic prog_vclk(input int code);
    int k;
    logic [7:0] ml, nl, hi, ds, base;
    logic [9:0] m, n;
    k = code % 3;
    base = 8'hc0 + 8'(4 * k);
    ml = 8'h81 + 8'(code);
    nl = 8'h42 + 8'(code);
    hi = 8'hcc | 8'(code % 4) | 8'((3 - code % 4) << 4);
    ds = {code[0], code[2:0], 1'b1, ~code[2:0]};
    m = {hi[1:0], ml};
    n = {hi[5:4], nl};
    wr(base, ml);
    wr(base + 8'h01, nl);
    wr(base + 8'h02, hi);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(vco_m[10*k +: 10]), 32'(em[k]));
    chk(32'(vco_n[10*k +: 10]), 32'(en[k]));
    wr(base + 8'h03, ds);
    #1;
    chk(32'(vclk_commit), 32'(1 << k));
    chk(32'(vco_m[10*k +: 10]), 32'(m));
    chk(32'(vco_n[10*k +: 10]), 32'(n));
    em[k] = m;
    en[k] = n;
    @(posedge sys_clk);
    #1;
    chk(32'(vclk_commit), 32'h0);
    chk(32'(vco_post_div_log2[3*k +: 3]), (code > 5) ? 5 : code);
    chk(32'(vco_loop_mul[5*k +: 5]), ds[2] ? 16 : 4);
    chk(32'(vco_ref_pre_div[3*k +: 3]), ds[1] ? 5 : 1);
    chk(32'(vco_ref_sel_div[3*k +: 3]), ds[0] ? 1 : 4);
    if (k == 2) begin
      chk(32'(vclk2_use_memclk), 32'(ds[7]));
    end
    rd(base, ml);
    rd(base + 8'h02, hi & 8'h33);
    rd(base + 8'h03, ds & ((k == 2) ? 8'hf7 : 8'h77));
  endtask

  task automatic mem_clock();
    wr(8'hce, 8'h3f);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hd5);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(mem_m), 32'h7f);
    chk(32'(mem_n), 32'h55);
    chk(32'(mem_post_div_log2), 32'h3);
    chk(32'(mem_ref_sel_div), 32'h1);
    chk(32'(mem_use_prog), 32'h0);
    rd(8'hcc, 8'h7f);
    rd(8'hce, 8'h31);
    wr(8'hce, 8'hde);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(mem_use_prog), 32'h1);
    chk(32'(mem_ref_sel_div), 32'h4);
    chk(32'(mem_post_div_log2), 32'h5);
    wr(8'hce, 8'h5e);
    wr(8'hcd, 8'h12);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(mem_use_prog), 32'h0);
    chk(32'(mem_n), 32'h12);
    wr(8'hce, 8'hde);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(mem_n), 32'h12);
    chk(32'(mem_use_prog), 32'h1);
  endtask

  task automatic strap_and_unmapped();
    @(posedge sys_clk);
    vclk_src_strap <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(32'(vclk_vco_en), 32'h0);
    @(posedge sys_clk);
    vclk_src_strap <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(32'(vclk_vco_en), 32'h1);
    wr(8'hcf, 8'ha5);
    rd(8'hcf, 8'h00);
    rd(8'hbf, 8'h00);
  endtask

  // ==========================================
  // main sequence
  initial begin
    srst = 1'b1;
    reg_index = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    vclk_src_strap = 1'b1;
    for (int i = 0; i < 3; i++) begin
      em[i] = 10'h000;
      en[i] = 10'h000;
    end
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check_reset_values();
    for (int c = 0; c < 8; c++) begin
      prog_vclk(c);
    end
    mem_clock();
    strap_and_unmapped();
    tally_and_finish();
  end
endmodule

`default_nettype wire
